/* File: inc/rtrs_pkg.sv */
package rtrs_pkg;
  // Serial register addresses (low five bits of each word)
  localparam logic [4:0] RTRS_ADDR_R2 = 5'h02;
  localparam logic [4:0] RTRS_ADDR_R3 = 5'h03;
  localparam logic [4:0] RTRS_ADDR_R5 = 5'h05;
  localparam logic [4:0] RTRS_ADDR_R6 = 5'h06;
  localparam logic [4:0] RTRS_ADDR_R7 = 5'h07;
  localparam int RTRS_ADDR_LSB = 0;
  localparam int RTRS_ADDR_MSB = 4;
  // Words with a side effect
  localparam logic [31:0] RTRS_ADC_START_WORD = 32'h0002A802;
  localparam logic [31:0] RTRS_ADC_READ_WORD = 32'h0189FAC3;
  // Field positions
  localparam int RTRS_INT_LSB = 17;
  localparam int RTRS_INT_MSB = 28;
  localparam int RTRS_FMSB_LSB = 5;
  localparam int RTRS_FMSB_MSB = 16;
  localparam int RTRS_FLSB_LSB = 5;
  localparam int RTRS_FLSB_MSB = 17;
  localparam int RTRS_RDIV_LSB = 5;
  localparam int RTRS_RDIV_MSB = 9;
  localparam int RTRS_DBL_BIT = 10;
  localparam int RTRS_HLV_BIT = 11;
  localparam int RTRS_FLSB_W = 13;
  // Reset values
  localparam logic [11:0] RTRS_INT_RST = 12'h000;
  localparam logic [4:0] RTRS_RDIV_RST = 5'h01;
  localparam logic [7:0] RTRS_CTRL_RST = 8'h01;
  // Converter timing
  localparam int RTRS_CLK_MHZ = 125;
  localparam int RTRS_ADC_CONV_NS = 16000;
  localparam int RTRS_ADC_CONV_CYC = RTRS_ADC_CONV_NS * RTRS_CLK_MHZ / 1000;
  localparam logic [11:0] RTRS_ADC_CNT_LOAD = 12'(RTRS_ADC_CONV_CYC - 1);
  // AXI4-Lite byte offsets and response codes
  localparam logic [7:0] RTRS_OFF_STATUS = 8'h00;
  localparam logic [7:0] RTRS_OFF_FRAC = 8'h04;
  localparam logic [7:0] RTRS_OFF_NWORD = 8'h08;
  localparam logic [7:0] RTRS_OFF_REFDIV = 8'h0C;
  localparam logic [7:0] RTRS_OFF_ADC = 8'h10;
  localparam logic [7:0] RTRS_OFF_RSEL = 8'h14;
  localparam logic [7:0] RTRS_OFF_RDATA = 8'h18;
  localparam logic [7:0] RTRS_OFF_CTRL = 8'h1C;
  localparam logic [1:0] RTRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTRS_RESP_SLVERR = 2'h2;
endpackage

/* File: inc/rtrs_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rtrs_mem_if;
  logic we;
  logic [4:0] waddr;
  logic [31:0] wdata;
  logic [4:0] raddr;
  logic [31:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: rtl/rtrs_regmem.sv */
`timescale 1ns/1ps
`default_nettype none
module rtrs_regmem (
  input wire logic aclk, // Clock
  rtrs_mem_if.mem mp // Write and read port
);
  logic [31:0] words [32];
  logic [31:0] rd;

  always_ff @(posedge aclk) begin
    if (mp.we) begin
      words[mp.waddr] <= mp.wdata;
    end
    rd <= words[mp.raddr];
  end

  assign mp.rdata = rd;
endmodule
`default_nettype wire

/* File: rtl/rtrs_top.sv */
// Functional notes
// - R2 start word begins a conversion
// - R3 readback word puts result on output
// - Output frequency from integer plus fraction
// - Fraction is upper part shifted plus lower
// - Comparison reference from doubler, divider, halving
`timescale 1ns/1ps
`default_nettype none
module rtrs_top (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset
  input wire logic spi_clk, // Serial clock pin
  input wire logic spi_data, // Serial data in
  input wire logic spi_le, // Latch enable pin
  output logic spi_dout, // Serial data out
  input wire logic [7:0] adc_code, // Converter sample
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  import rtrs_pkg::*;

  typedef struct packed {
    logic [2:0] ck;
    logic [1:0] dt;
    logic [2:0] le;
    logic [7:0] adc1;
    logic [7:0] adc2;
    logic [31:0] sh;
    logic [11:0] int_w;
    logic [11:0] fmsb;
    logic [12:0] flsb;
    logic dbl;
    logic hlv;
    logic [4:0] rdiv;
    logic adc_busy;
    logic adc_done;
    logic [11:0] adc_cnt;
    logic [7:0] adc_res;
    logic rb_arm;
    logic [31:0] dout_sh;
    logic dout;
    logic we;
    logic [4:0] waddr;
    logic [31:0] wdata;
    logic [7:0] ctrl;
    logic [4:0] rsel;
    logic aw_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtrs_state_s;

  rtrs_state_s st;
  rtrs_state_s next_st;
  rtrs_mem_if mif ();
  logic ck_rise;
  logic ck_fall;
  logic le_rise;
  logic [24:0] frac_w;
  logic [5:0] ref_mul;
  logic [5:0] ref_den;

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= RTRS_OFF_CTRL;
  endfunction

  rtrs_regmem u_mem (
    .aclk(aclk),
    .mp(mif.mem)
  );

  assign mif.we = st.we;
  assign mif.waddr = st.waddr;
  assign mif.wdata = st.wdata;
  assign mif.raddr = st.rsel;

  assign ck_rise = st.ck[1] & ~st.ck[2];
  assign ck_fall = ~st.ck[1] & st.ck[2];
  assign le_rise = st.le[1] & ~st.le[2] & st.ctrl[0];
  assign frac_w = {st.fmsb, 13'h0000} + 25'(st.flsb);
  assign ref_mul = 6'h01 + 6'(st.dbl);
  assign ref_den = st.hlv ? 6'({st.rdiv, 1'b0}) : 6'(st.rdiv);

  always_comb begin
    next_st = st;
    next_st.ck = {st.ck[1:0], spi_clk};
    next_st.dt = {st.dt[0], spi_data};
    next_st.le = {st.le[1:0], spi_le};
    next_st.adc1 = adc_code;
    next_st.adc2 = st.adc1;
    next_st.we = 1'b0;
    // Serial word shifts in MSB first
    if (ck_rise) begin
      next_st.sh = {st.sh[30:0], st.dt[1]};
    end
    if (ck_fall && st.rb_arm) begin
      next_st.dout_sh = {st.dout_sh[30:0], 1'b0};
      next_st.dout = st.dout_sh[30];
    end
    // Converter countdown
    if (st.adc_busy) begin
      if (st.adc_cnt == 12'h000) begin
        next_st.adc_busy = 1'b0;
        next_st.adc_done = 1'b1;
        next_st.adc_res = st.adc2;
      end else begin
        next_st.adc_cnt = st.adc_cnt - 12'h001;
      end
    end
    if (le_rise) begin
      next_st.we = 1'b1;
      next_st.waddr = st.sh[RTRS_ADDR_MSB:RTRS_ADDR_LSB];
      next_st.wdata = st.sh;
      next_st.rb_arm = 1'b0;
      case (st.sh[RTRS_ADDR_MSB:RTRS_ADDR_LSB])
        RTRS_ADDR_R2: begin
          if (st.sh == RTRS_ADC_START_WORD) begin
            next_st.adc_busy = 1'b1;
            next_st.adc_done = 1'b0;
            next_st.adc_cnt = RTRS_ADC_CNT_LOAD;
          end
        end
        RTRS_ADDR_R3: begin
          if (st.sh == RTRS_ADC_READ_WORD) begin
            next_st.rb_arm = 1'b1;
            next_st.dout_sh = {st.adc_res, 24'h000000};
            next_st.dout = st.adc_res[7];
          end
        end
        RTRS_ADDR_R5: begin
          next_st.int_w = st.sh[RTRS_INT_MSB:RTRS_INT_LSB];
          next_st.fmsb = st.sh[RTRS_FMSB_MSB:RTRS_FMSB_LSB];
        end
        RTRS_ADDR_R6: begin
          next_st.flsb = st.sh[RTRS_FLSB_MSB:RTRS_FLSB_LSB];
        end
        RTRS_ADDR_R7: begin
          next_st.rdiv = st.sh[RTRS_RDIV_MSB:RTRS_RDIV_LSB];
          next_st.dbl = st.sh[RTRS_DBL_BIT];
          next_st.hlv = st.sh[RTRS_HLV_BIT];
        end
        default: begin
          next_st.rb_arm = 1'b0;
        end
      endcase
    end
    // AXI4-Lite write: ready one cycle, then response
    if (st.aw_rdy) begin
      next_st.aw_rdy = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(s_axi_awaddr) ? RTRS_RESP_OKAY : RTRS_RESP_SLVERR;
      if (s_axi_wstrb[0] && s_axi_awaddr == RTRS_OFF_RSEL) begin
        next_st.rsel = s_axi_wdata[4:0];
      end
      if (s_axi_wstrb[0] && s_axi_awaddr == RTRS_OFF_CTRL) begin
        next_st.ctrl = s_axi_wdata[7:0];
      end
    end else if (st.bvalid) begin
      if (s_axi_bready) begin
        next_st.bvalid = 1'b0;
      end
    end else if (s_axi_awvalid && s_axi_wvalid) begin
      next_st.aw_rdy = 1'b1;
    end
    // AXI4-Lite read
    if (st.ar_rdy) begin
      next_st.ar_rdy = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = is_mapped(s_axi_araddr) ? RTRS_RESP_OKAY : RTRS_RESP_SLVERR;
      case (s_axi_araddr)
        RTRS_OFF_STATUS: next_st.rdata = {28'h0000000, st.rb_arm, st.adc_done, st.adc_busy, st.ctrl[0]};
        RTRS_OFF_FRAC: next_st.rdata = {7'h00, frac_w};
        RTRS_OFF_NWORD: next_st.rdata = {20'h00000, st.int_w};
        RTRS_OFF_REFDIV: next_st.rdata = {18'h00000, ref_den, 2'h0, ref_mul};
        RTRS_OFF_ADC: next_st.rdata = {24'h000000, st.adc_res};
        RTRS_OFF_RSEL: next_st.rdata = {27'h0000000, st.rsel};
        RTRS_OFF_RDATA: next_st.rdata = mif.rdata;
        RTRS_OFF_CTRL: next_st.rdata = {24'h000000, st.ctrl};
        default: next_st.rdata = 32'h00000000;
      endcase
    end else if (st.rvalid) begin
      if (s_axi_rready) begin
        next_st.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      next_st.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.int_w <= RTRS_INT_RST;
      st.rdiv <= RTRS_RDIV_RST;
      st.ctrl <= RTRS_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign spi_dout = st.dout;
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.aw_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_latch(logic [4:0] a);
    le_rise && st.sh[RTRS_ADDR_MSB:RTRS_ADDR_LSB] == a;
  endsequence

  a_adc_start: assert property (s_latch(RTRS_ADDR_R2) ##0 st.sh == RTRS_ADC_START_WORD |=> st.adc_busy)
    else $error("conversion did not start");
  a_adc_hold: assert property ($rose(st.adc_busy) |-> st.adc_busy [*8] ##1 !st.adc_done)
    else $error("conversion ended too soon");
  a_dout_load: assert property (s_latch(RTRS_ADDR_R3) ##0 st.sh == RTRS_ADC_READ_WORD
    |=> st.rb_arm && spi_dout == $past(st.adc_res[7]))
    else $error("readback not loaded");
  a_dout_shift: assert property (st.rb_arm && ck_fall && !le_rise |=> spi_dout == $past(st.dout_sh[30]))
    else $error("readback bit wrong");
  a_int_take: assert property (s_latch(RTRS_ADDR_R5) |=> st.int_w == $past(st.sh[RTRS_INT_MSB:RTRS_INT_LSB]))
    else $error("integer word not taken");
  a_frac_form: assert property (s_latch(RTRS_ADDR_R6) ##1 !le_rise
    |=> frac_w[RTRS_FLSB_W-1:0] == $past(st.sh[RTRS_FLSB_MSB:RTRS_FLSB_LSB], 2))
    else $error("fraction lower part wrong");
  a_ref_bits: assert property (s_latch(RTRS_ADDR_R7) |=> ref_mul == 6'h01 + 6'($past(st.sh[RTRS_DBL_BIT])))
    else $error("doubler not applied");
  a_axi_bresp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write response missing");
endmodule
`default_nettype wire

/* File: testbench/rtrs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtrs_host_model #(
  parameter int US_DIV = 100 // Shortens host waits
) (
  input wire logic aclk, // System clock
  output logic spi_clk = 1'h0, // Serial clock
  output logic spi_data = 1'h0, // Serial data
  output logic spi_le = 1'h0, // Latch enable
  input wire logic spi_dout // Readback data
);
  import rtrs_pkg::*;
  localparam logic [31:0] SEQ [21] = '{32'h800FE500,
    32'h2A20B929, 32'h01800827, 32'h00000006, 32'h01E38005,
    32'h00000004, 32'h01897803, 32'h00020642, 32'hFFF7FFE1, 32'h800FE700,
    32'h800FE560, 32'h800FED60, 32'h800FE5A0, 32'h800FF5A0, 32'h2800B929, 32'h0100A027,
    32'h00000006, 32'h00F04005, 32'h00002004, 32'h0189F803, 32'h0000010B};
  task automatic pause(input int us);
    repeat (us * 125 / US_DIV) @(posedge aclk);
  endtask
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      spi_data = w[i];
      #62.5 spi_clk = 1'h1;
      #62.5 spi_clk = 1'h0;
    end
    spi_data = ~w[0];
    #62.5 spi_le = 1'h1;
    #125 spi_le = 1'h0;
    #250;
  endtask
  task automatic recal(input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      send(SEQ[i]);
      case (i)
        9: pause(1200);
        11, 13: pause(500);
        19: pause(100);
      endcase
    end
  endtask
  task automatic temp(output logic [7:0] code, output real deg);
    send(32'h00012064);
    send(RTRS_ADC_START_WORD);
    repeat (RTRS_ADC_CONV_CYC + 8) @(posedge aclk);
    send(RTRS_ADC_READ_WORD);
    for (int i = 7; i >= 0; i--) begin
      code[i] = spi_dout;
      #62.5 spi_clk = 1'h1;
      #62.5 spi_clk = 1'h0;
      #62.5;
    end
    send(32'h00002064);
    send(32'h00020642);
    deg = (code * 7.33e-3 - 0.699) / 6.4e-3;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtrs_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, spi_clk, spi_data, spi_le, spi_dout;
  logic [7:0] adc_code = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0, total_checks = 0;
  always #4 aclk = ~aclk;
  rtrs_top u_dut (.*, .s_axi_wstrb(4'hF));
  rtrs_host_model u_host (.*);
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RTRS_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && ++n < 50);
    s_axi_bready <= 1'h0;
    chk(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'h1, er}));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RTRS_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && ++n < 50);
    s_axi_rready <= 1'h0;
    chk(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'h1, er}));
    chk(s_axi_rdata, ed);
  endtask
  function automatic logic [31:0] mk(input int i, input logic [4:0] a);
    return {(i == 0) ? 27'h7FFFFFF : 27'($urandom()), a};
  endfunction
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [31:0] w5, w6, w7;
    logic [7:0] code;
    real deg;
    void'($urandom(59202));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(RTRS_OFF_CTRL, 32'h1);
    rd(RTRS_OFF_STATUS, 32'h1);
    rd(RTRS_OFF_REFDIV, 32'h101);
    wr(8'h20, $urandom(), RTRS_RESP_SLVERR);
    rd(8'h20, 32'h0, RTRS_RESP_SLVERR);
    u_host.recal(0, 3);
    rd(RTRS_OFF_REFDIV, 32'h201);
    u_host.recal(3, 21);
    rd(RTRS_OFF_NWORD, 32'h78);
    rd(RTRS_OFF_FRAC, 32'h00400000);
    rd(RTRS_OFF_REFDIV, 32'h101);
    wr(RTRS_OFF_RSEL, 32'h0);
    rd(RTRS_OFF_RDATA, 32'h800FF5A0);
    wr(RTRS_OFF_RSEL, 32'hB);
    rd(RTRS_OFF_RDATA, 32'h0000010B);
    for (int i = 0; i < 6; i++) begin
      w5 = mk(i, RTRS_ADDR_R5);
      w6 = mk(i, RTRS_ADDR_R6);
      w7 = mk(i, RTRS_ADDR_R7);
      u_host.send(w5);
      u_host.send(w6);
      u_host.send(w7);
      rd(RTRS_OFF_NWORD, {20'h0, w5[28:17]});
      rd(RTRS_OFF_FRAC, {7'h0, w5[16:5], w6[17:5]});
      rd(RTRS_OFF_REFDIV, {18'h0, 6'(w7[9:5] * (w7[11] + 1)), 2'h0, 6'(w7[10] + 1)});
    end
    wr(RTRS_OFF_CTRL, 32'h0);
    u_host.send(mk(1, RTRS_ADDR_R5));
    rd(RTRS_OFF_NWORD, {20'h0, w5[28:17]});
    rd(RTRS_OFF_STATUS, 32'h0);
    wr(RTRS_OFF_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      adc_code <= (i == 0) ? 8'h81 : 8'($urandom());
      u_host.temp(code, deg);
      chk(32'(code), 32'(adc_code));
      rd(RTRS_OFF_ADC, 32'(adc_code));
      rd(RTRS_OFF_STATUS, 32'h5);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
